// File: common/roc_pkg.sv
// Package for the relay output contact control block: register map, field layout, timing
package roc_pkg;
    localparam int ROC_NUM_PLAIN = 4;
    localparam int ROC_NUM_LATCH = 2;
    localparam int ROC_SEL_W = 4;
    localparam int ROC_NUM_OPS = 16;
    localparam int ROC_DRIVE_MS = 50;
    localparam int ROC_CLK_HZ = 10_000_000;
    localparam int ROC_DRIVE_CYC = ROC_DRIVE_MS * (ROC_CLK_HZ / 1000);
    localparam logic [7:0] ROC_ADDR_CTRL = 8'h00;
    localparam logic [7:0] ROC_ADDR_SEL = 8'h04;
    localparam logic [7:0] ROC_ADDR_LSEL = 8'h08;
    localparam logic [7:0] ROC_ADDR_STAT = 8'h0C;
    localparam logic [7:0] ROC_ADDR_EVT = 8'h10;
    localparam logic [31:0] ROC_CTRL_RST = 32'h0000_0000;
    localparam int ROC_CTRL_EVEN_POS = 0;
    localparam int ROC_CTRL_DOM_POS = 8;
    localparam int ROC_CTRL_HOLD_POS = 16;
    localparam int ROC_SEL_STRIDE = 8;
    localparam int ROC_SEL_HOLD_POS = 4;
    localparam int ROC_STAT_PLAIN_POS = 0;
    localparam int ROC_STAT_LPOS_POS = 8;
    localparam int ROC_STAT_ERR_POS = 16;
    localparam int ROC_STAT_INIT_POS = 24;
    localparam logic [1:0] ROC_RESP_OKAY = 2'b00;
    localparam logic [1:0] ROC_RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } roc_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } roc_axi_rsp_t;

    typedef struct packed {
        logic close_coil;
        logic open_coil;
    } roc_coil_t;

    typedef enum logic [1:0] {
        ROC_L_IDLE = 2'b00,
        ROC_L_CLOSING = 2'b01,
        ROC_L_OPENING = 2'b10
    } roc_lstate_t;
endpackage : roc_pkg

// File: verilog/roc_latch_ctl.sv
// One bistable contact: sealed-in close/open coil drive, dominance and readback check
`timescale 1ns/1ps
`default_nettype none
module roc_latch_ctl
    import roc_pkg::*;
#(
    parameter int DRIVE_CYC = ROC_DRIVE_CYC
) (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_init,
    input wire logic i_pass,
    input wire logic i_close_cmd,
    input wire logic i_open_cmd,
    input wire logic i_close_dom,
    input wire logic i_pos,
    output roc_coil_t o_coil,
    output logic o_cmd_pos,
    output logic o_err
);
    if (DRIVE_CYC < 2) begin : g_bad_drive
        $error("DRIVE_CYC too small");
    end

    typedef struct packed {
        roc_lstate_t st;
        logic cmd_pos;
        logic [31:0] cnt;
        logic err;
    } roc_latch_st_t;

    roc_latch_st_t state_reg;
    roc_latch_st_t state_next;
    logic want_close;
    logic want_open;

    always_comb begin
        state_next = state_reg;
        want_close = i_close_cmd && (!i_open_cmd || i_close_dom);
        want_open = i_open_cmd && (!i_close_cmd || !i_close_dom);
        if (i_init) begin
            state_next.cmd_pos = i_pos;
            state_next.st = ROC_L_IDLE;
            state_next.err = 1'b0;
        end else begin
            case (state_reg.st)
                ROC_L_IDLE: begin
                    // Close ignored when already closed and open is off, and vice versa
                    if (i_pass && want_close && !state_reg.cmd_pos) begin
                        state_next.st = ROC_L_CLOSING;
                        state_next.cmd_pos = 1'b1;
                        state_next.cnt = '0;
                    end else if (i_pass && want_open && state_reg.cmd_pos) begin
                        state_next.st = ROC_L_OPENING;
                        state_next.cmd_pos = 1'b0;
                        state_next.cnt = '0;
                    end
                end
                ROC_L_CLOSING, ROC_L_OPENING: begin
                    state_next.cnt = state_reg.cnt + 32'd1;
                    if (i_pos == state_reg.cmd_pos || state_reg.cnt == 32'(DRIVE_CYC - 1)) begin
                        state_next.st = ROC_L_IDLE;
                    end
                end
                default: state_next.st = ROC_L_IDLE;
            endcase
            // Mismatch only judged when no coil is moving the contact
            state_next.err = (state_next.st == ROC_L_IDLE) && (state_reg.st == ROC_L_IDLE)
                && (i_pos != state_reg.cmd_pos);
        end
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_reg <= '{st: ROC_L_IDLE, cmd_pos: 1'b0, cnt: 32'h0000_0000, err: 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_coil.close_coil = (state_reg.st == ROC_L_CLOSING);
    assign o_coil.open_coil = (state_reg.st == ROC_L_OPENING);
    assign o_cmd_pos = state_reg.cmd_pos;
    assign o_err = state_reg.err;
endmodule : roc_latch_ctl
`default_nettype wire

// File: verilog/roc_top.sv
// Relay output contact control: plain and bistable contacts with an AXI4-Lite register file
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module roc_top
    import roc_pkg::*;
#(
    parameter int NUM_PLAIN = ROC_NUM_PLAIN,
    parameter int NUM_LATCH = ROC_NUM_LATCH,
    parameter int DRIVE_CYC = ROC_DRIVE_CYC
) (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire roc_axi_req_t i_axi,
    output roc_axi_rsp_t o_axi,
    input wire logic i_pass,
    input wire logic [ROC_NUM_OPS-1:0] i_operands,
    input wire logic [ROC_NUM_LATCH-1:0] i_close_cmd,
    input wire logic [ROC_NUM_LATCH-1:0] i_open_cmd,
    input wire logic [ROC_NUM_PLAIN-1:0] i_trip_current,
    input wire logic [ROC_NUM_LATCH-1:0] i_latch_pos,
    output logic [ROC_NUM_PLAIN-1:0] o_plain_out,
    output logic [ROC_NUM_PLAIN-1:0] o_trip_current_present_flag,
    output logic [ROC_NUM_PLAIN-1:0] o_trip_current_absent_flag,
    output roc_coil_t [ROC_NUM_LATCH-1:0] o_coil,
    output logic o_latch_err,
    output logic o_logic_ready,
    output logic o_event,
    output logic [7:0] o_event_src
);
    if (NUM_PLAIN != ROC_NUM_PLAIN || NUM_LATCH != ROC_NUM_LATCH) begin : g_bad_count
        $error("Channel counts fixed by package");
    end

    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] sel;
        logic [31:0] lsel;
        logic [NUM_PLAIN-1:0] out;
        logic [NUM_PLAIN-1:0] cur1;
        logic [NUM_PLAIN-1:0] cur2;
        logic [NUM_LATCH-1:0] pos1;
        logic [NUM_LATCH-1:0] pos2;
        logic [1:0] init_cnt;
        logic ready;
        logic err_prev;
        logic evt;
        logic [7:0] evt_src;
        logic [7:0] evt_cnt;
        logic [31:0] evt_log;
        logic bvalid;
        logic [1:0] bresp;
        logic aw_got;
        logic [7:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } roc_top_st_t;

    roc_top_st_t state_reg;
    roc_top_st_t state_next;
    logic [NUM_LATCH-1:0] lat_cmd_pos;
    logic [NUM_LATCH-1:0] lat_err;
    logic [NUM_LATCH-1:0] lat_init;
    logic [NUM_PLAIN-1:0] op_val;
    logic [NUM_PLAIN-1:0] hold_val;
    logic [NUM_PLAIN-1:0] hold_en;
    logic any_err;

    genvar g;
    generate
        for (g = 0; g < NUM_PLAIN; g++) begin : g_plain
            assign op_val[g] = i_operands[state_reg.sel[g*ROC_SEL_STRIDE +: ROC_SEL_W]];
            assign hold_val[g] = i_operands[state_reg.sel[g*ROC_SEL_STRIDE+ROC_SEL_HOLD_POS +: ROC_SEL_W]];
            assign hold_en[g] = state_reg.ctrl[ROC_CTRL_HOLD_POS+g];
        end
        for (g = 0; g < NUM_LATCH; g++) begin : g_latch
            assign lat_init[g] = !state_reg.ready;
            roc_latch_ctl #(
                .DRIVE_CYC(DRIVE_CYC)
            ) u_latch (
                .i_mclk(i_mclk),
                .i_sys_rst(i_sys_rst),
                .i_init(lat_init[g]),
                .i_pass(i_pass && state_reg.ready),
                .i_close_cmd(i_close_cmd[g]),
                .i_open_cmd(i_open_cmd[g]),
                .i_close_dom(state_reg.ctrl[ROC_CTRL_DOM_POS+g]),
                .i_pos(state_reg.pos2[g]),
                .o_coil(o_coil[g]),
                .o_cmd_pos(lat_cmd_pos[g]),
                .o_err(lat_err[g])
            );
        end
    endgenerate

    // One shared error covers every latching contact; STAT tells which one
    assign any_err = |lat_err;

    always_comb begin
        logic aw_now;
        logic w_now;
        logic [NUM_PLAIN-1:0] out_new;
        logic [NUM_PLAIN-1:0] out_diff;
        logic [31:0] stat_word;
        state_next = state_reg;
        aw_now = 1'b0;
        w_now = 1'b0;
        out_new = state_reg.out;
        out_diff = '0;
        stat_word = 32'h0000_0000;
        state_next.cur1 = i_trip_current;
        state_next.cur2 = state_reg.cur1;
        state_next.pos1 = i_latch_pos;
        state_next.pos2 = state_reg.pos1;
        state_next.evt = 1'b0;
        // Synchroniser depth must settle before positions are trusted
        if (!state_reg.ready) begin
            state_next.init_cnt = state_reg.init_cnt + 2'd1;
            if (state_reg.init_cnt == 2'd3) begin
                state_next.ready = 1'b1;
            end
        end
        if (i_pass && state_reg.ready) begin
            out_new = op_val | (state_reg.out & hold_val & hold_en);
            state_next.out = out_new;
        end
        // Outputs without events enabled still switch; only their event is suppressed
        out_diff = out_new ^ state_reg.out;
        if (state_reg.ready && (out_diff & state_reg.ctrl[ROC_CTRL_EVEN_POS +: NUM_PLAIN]) != '0) begin
            state_next.evt = 1'b1;
            state_next.evt_src = 8'(out_diff);
            state_next.evt_cnt = state_reg.evt_cnt + 8'd1;
        end else begin
            // An error rise that meets an output event waits for the next cycle without one instead of being lost
            state_next.err_prev = any_err;
            if (any_err && !state_reg.err_prev) begin
                state_next.evt = 1'b1;
                state_next.evt_src = 8'h80;
                state_next.evt_cnt = state_reg.evt_cnt + 8'd1;
            end
        end
        if (state_next.evt) begin
            state_next.evt_log = {16'h0000, state_next.evt_cnt, state_next.evt_src};
        end
        // Address and data may come in either order; the response waits for both
        if (i_axi.awvalid && !state_reg.aw_got) begin
            state_next.aw_got = 1'b1;
            state_next.awaddr = i_axi.awaddr;
        end
        if (i_axi.wvalid && !state_reg.w_got) begin
            state_next.w_got = 1'b1;
            state_next.wdata = i_axi.wdata;
        end
        aw_now = state_reg.aw_got;
        w_now = state_reg.w_got;
        if (aw_now && w_now && !state_reg.bvalid) begin
            state_next.bvalid = 1'b1;
            state_next.bresp = ROC_RESP_OKAY;
            state_next.aw_got = 1'b0;
            state_next.w_got = 1'b0;
            // Read-only registers accept writes quietly so software can probe them
            case ({state_reg.awaddr[7:2], 2'b00})
                ROC_ADDR_CTRL: state_next.ctrl = state_reg.wdata;
                ROC_ADDR_SEL: state_next.sel = state_reg.wdata;
                ROC_ADDR_LSEL: state_next.lsel = state_reg.wdata;
                ROC_ADDR_STAT, ROC_ADDR_EVT: ;
                default: state_next.bresp = ROC_RESP_SLVERR;
            endcase
        end
        if (state_reg.bvalid && i_axi.bready) begin
            state_next.bvalid = 1'b0;
        end
        if (i_axi.arvalid && !state_reg.rvalid) begin
            state_next.rvalid = 1'b1;
            state_next.rresp = ROC_RESP_OKAY;
            case ({i_axi.araddr[7:2], 2'b00})
                ROC_ADDR_CTRL: state_next.rdata = state_reg.ctrl;
                ROC_ADDR_SEL: state_next.rdata = state_reg.sel;
                ROC_ADDR_LSEL: state_next.rdata = state_reg.lsel;
                ROC_ADDR_STAT: begin
                    stat_word[ROC_STAT_PLAIN_POS +: NUM_PLAIN] = state_reg.out;
                    stat_word[ROC_STAT_LPOS_POS +: NUM_LATCH] = lat_cmd_pos;
                    stat_word[ROC_STAT_ERR_POS +: NUM_LATCH] = lat_err;
                    stat_word[ROC_STAT_INIT_POS] = state_reg.ready;
                    state_next.rdata = stat_word;
                end
                ROC_ADDR_EVT: state_next.rdata = state_reg.evt_log;
                default: begin
                    state_next.rdata = 32'h0000_0000;
                    state_next.rresp = ROC_RESP_SLVERR;
                end
            endcase
        end
        if (state_reg.rvalid && i_axi.rready) begin
            state_next.rvalid = 1'b0;
        end
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_reg <= '0;
            state_reg.ctrl <= ROC_CTRL_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_axi.awready = !state_reg.aw_got;
    assign o_axi.wready = !state_reg.w_got;
    assign o_axi.bvalid = state_reg.bvalid;
    assign o_axi.bresp = state_reg.bresp;
    assign o_axi.arready = !state_reg.rvalid;
    assign o_axi.rvalid = state_reg.rvalid;
    assign o_axi.rdata = state_reg.rdata;
    assign o_axi.rresp = state_reg.rresp;
    assign o_plain_out = state_reg.out;
    assign o_trip_current_present_flag = state_reg.cur2;
    assign o_trip_current_absent_flag = ~state_reg.cur2;
    assign o_latch_err = any_err;
    assign o_logic_ready = state_reg.ready;
    assign o_event = state_reg.evt;
    assign o_event_src = state_reg.evt_src;
endmodule : roc_top
`default_nettype wire

// File: bench/roc_top_properties.sv
// Port-level checker for the relay output contact control block
`timescale 1ns/1ps
`default_nettype none
module roc_top_properties
    import roc_pkg::*;
#(
    parameter int DRIVE_CYC = ROC_DRIVE_CYC
) (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_pass,
    input wire logic [ROC_NUM_LATCH-1:0] i_latch_pos,
    input wire logic [ROC_NUM_PLAIN-1:0] o_plain_out,
    input wire logic [ROC_NUM_PLAIN-1:0] o_trip_current_present_flag,
    input wire logic [ROC_NUM_PLAIN-1:0] o_trip_current_absent_flag,
    input wire roc_coil_t [ROC_NUM_LATCH-1:0] o_coil,
    input wire logic o_latch_err,
    input wire logic o_logic_ready,
    input wire logic o_event,
    input wire logic [7:0] o_event_src
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    // Counts how long the first contact's coils stay driven
    int drive_cnt;
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            drive_cnt <= 0;
        end else begin
            drive_cnt <= (o_coil[0] != '0) ? drive_cnt + 1 : 0;
        end
    end
    property p_flags; o_trip_current_absent_flag == ~o_trip_current_present_flag; endproperty
    a_flags: assert property (p_flags) else $error("flag pair");
    property p_excl; !(o_coil[0].close_coil && o_coil[0].open_coil); endproperty
    a_excl: assert property (p_excl) else $error("both coils");
    property p_ready; !o_logic_ready |-> o_coil == '0 && o_plain_out == '0; endproperty
    a_ready: assert property (p_ready) else $error("drive before ready");
    property p_plain; $changed(o_plain_out) |-> $past(i_pass) && $past(o_logic_ready); endproperty
    a_plain: assert property (p_plain) else $error("output moved off pass");
    property p_event;
        o_event |-> (o_event_src[7] ? o_latch_err : o_event_src[3:0] == ($past(o_plain_out) ^ o_plain_out));
    endproperty
    a_event: assert property (p_event) else $error("stray event");
    property p_seal; $rose(o_coil[0].close_coil) |-> $past(i_pass); endproperty
    a_seal: assert property (p_seal) else $error("close coil off pass");
    property p_stop; drive_cnt <= DRIVE_CYC; endproperty
    a_stop: assert property (p_stop) else $error("coil drive too long");
    property p_match; $rose(i_latch_pos[0]) |-> ##[0:4] !o_coil[0].close_coil; endproperty
    a_match: assert property (p_match) else $error("coil kept after match");
endmodule : roc_top_properties
bind roc_top roc_top_properties #(.DRIVE_CYC(DRIVE_CYC)) u_props (.i_mclk, .i_sys_rst, .i_pass, .i_latch_pos,
    .o_plain_out, .o_trip_current_present_flag, .o_trip_current_absent_flag, .o_coil, .o_latch_err,
    .o_logic_ready, .o_event, .o_event_src);
`default_nettype wire

// File: bench/roc_coil_model.sv
// Coil drivers and bistable contacts with position readback
`timescale 1ns/1ps
`default_nettype none
module roc_coil_model
    import roc_pkg::*;
#(
    parameter int DLY = 3,
    parameter logic [ROC_NUM_LATCH-1:0] INIT = '0
) (
    input wire logic i_mclk,
    input wire logic i_stuck,
    input wire roc_coil_t [ROC_NUM_LATCH-1:0] i_coil,
    output logic [ROC_NUM_LATCH-1:0] o_pos
);
    int cnt [ROC_NUM_LATCH];
    // Contacts keep their position without power, so the start value is free
    initial o_pos = INIT;
    always @(posedge i_mclk) begin
        for (int k = 0; k < ROC_NUM_LATCH; k++) begin
            // A stuck armature never moves, which is what the readback check must catch
            if (i_coil[k] == '0 || i_stuck) begin
                cnt[k] <= 0;
            end else if (cnt[k] == DLY) begin
                o_pos[k] <= i_coil[k].close_coil;
            end else begin
                cnt[k] <= cnt[k] + 1;
            end
        end
    end
endmodule : roc_coil_model
`default_nettype wire

// File: bench/test_roc_top.sv
// Self-checking bench for the relay output contact control block
`timescale 1ns/1ps
`default_nettype none
module test_roc_top;
    import roc_pkg::*;
    localparam int DRV = 20;
    // Overlap is scaled down like the coil drive time so the run stays short
    localparam int OVL = 10;
    logic i_mclk, i_sys_rst, i_pass, stuck;
    roc_axi_req_t i_axi;
    roc_axi_rsp_t o_axi;
    logic [ROC_NUM_OPS-1:0] i_operands;
    logic [ROC_NUM_LATCH-1:0] i_close_cmd, i_open_cmd, i_latch_pos;
    logic [ROC_NUM_PLAIN-1:0] i_trip_current, o_plain_out, o_trip_current_present_flag, o_trip_current_absent_flag;
    roc_coil_t [ROC_NUM_LATCH-1:0] o_coil;
    logic o_latch_err, o_logic_ready, o_event;
    logic [7:0] o_event_src;
    logic [31:0] d;
    logic [1:0] r;
    int mismatches, checks;
    roc_top #(.DRIVE_CYC(DRV)) dut (.i_mclk, .i_sys_rst, .i_axi, .o_axi, .i_pass, .i_operands, .i_close_cmd,
        .i_open_cmd, .i_trip_current, .i_latch_pos, .o_plain_out, .o_trip_current_present_flag,
        .o_trip_current_absent_flag, .o_coil, .o_latch_err, .o_logic_ready, .o_event, .o_event_src);
    roc_coil_model #(.INIT(2'b10)) u_coil (.i_mclk, .i_stuck(stuck), .i_coil(o_coil), .o_pos(i_latch_pos));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic ta, tw, tb;
        @(posedge i_mclk);
        i_axi <= '{awvalid: 1, awaddr: a, wvalid: 1, wdata: v, wstrb: 4'hF, bready: 1, default: 0};
        tb = 0;
        while (!tb) begin
            @(negedge i_mclk);
            ta = o_axi.awready;
            tw = o_axi.wready;
            tb = o_axi.bvalid;
            r = o_axi.bresp;
            @(posedge i_mclk);
            if (ta) i_axi.awvalid <= 0;
            if (tw) i_axi.wvalid <= 0;
        end
        i_axi.bready <= 0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        logic ta, tv;
        @(posedge i_mclk);
        i_axi <= '{arvalid: 1, araddr: a, rready: 1, default: 0};
        tv = 0;
        while (!tv) begin
            @(negedge i_mclk);
            ta = o_axi.arready;
            tv = o_axi.rvalid;
            d = o_axi.rdata;
            r = o_axi.rresp;
            @(posedge i_mclk);
            if (ta) i_axi.arvalid <= 0;
        end
        i_axi.rready <= 0;
    endtask : rd
    // One protection pass; commands stay as levels afterwards
    task automatic pass(input logic [15:0] op, input logic [1:0] cl, input logic [1:0] opn);
        @(posedge i_mclk);
        i_pass <= 1;
        i_operands <= op;
        i_close_cmd <= cl;
        i_open_cmd <= opn;
        @(posedge i_mclk);
        i_pass <= 0;
        @(negedge i_mclk);
    endtask : pass
    task automatic t_regs();
        rd(ROC_ADDR_STAT);
        chk(d, 32'h0100_0200);
        rd(ROC_ADDR_CTRL);
        chk(d, ROC_CTRL_RST);
        wr(ROC_ADDR_STAT, 32'hFFFF_FFFF);
        chk(r, ROC_RESP_OKAY);
        rd(ROC_ADDR_STAT);
        chk(d, 32'h0100_0200);
        rd(8'h40);
        chk({d[29:0], r}, {30'h0000_0000, ROC_RESP_SLVERR});
        wr(ROC_ADDR_LSEL, 32'hA5A5_5A5A);
        rd(ROC_ADDR_LSEL);
        chk(d, 32'hA5A5_5A5A);
        wr(8'h40, 32'h0000_0001);
        chk(r, ROC_RESP_SLVERR);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_plain();
        wr(ROC_ADDR_CTRL, 32'h0001_0101);
        wr(ROC_ADDR_SEL, 32'h0000_0021);
        pass(16'h0002, 0, 0);
        chk({o_event, o_event_src, o_plain_out}, {1'b1, 8'h01, 4'h1});
        pass(16'h0004, 0, 0);
        chk({o_event, o_plain_out}, 5'h01);
        pass(16'h0000, 0, 0);
        chk({o_event, o_event_src, o_plain_out}, {1'b1, 8'h01, 4'h0});
        pass(16'h0001, 0, 0);
        chk({o_event, o_plain_out}, 5'h0E);
        @(posedge i_mclk);
        i_trip_current <= 4'b0101;
        repeat (4) @(negedge i_mclk);
        chk({o_trip_current_present_flag, o_trip_current_absent_flag}, 8'h5A);
        $display("t_plain done");
    endtask : t_plain
    task automatic t_latch();
        pass(0, 2'b01, 0);
        chk(o_coil[0], 2'b10);
        repeat (10) @(negedge i_mclk);
        chk(o_coil[0], 0);
        rd(ROC_ADDR_STAT);
        chk(d[9:8], 2'b11);
        pass(0, 0, 0);
        pass(0, 2'b01, 0);
        chk(o_coil[0], 0);
        pass(0, 2'b01, 2'b01);
        chk(o_coil[0], 0);
        wr(ROC_ADDR_CTRL, 32'h0001_0001);
        pass(0, 2'b01, 2'b01);
        chk(o_coil[0], 2'b01);
        pass(0, 0, 0);
        chk(o_coil[0], 2'b01);
        repeat (10) @(negedge i_mclk);
        pass(0, 0, 2'b01);
        chk({o_coil[0], o_latch_err}, 0);
        $display("t_latch done");
    endtask : t_latch
    task automatic t_err();
        @(posedge i_mclk);
        stuck <= 1;
        pass(0, 2'b01, 0);
        chk(o_coil[0], 2'b10);
        repeat (DRV + 8) @(negedge i_mclk);
        chk({o_coil[0], o_latch_err}, 3'b001);
        rd(ROC_ADDR_EVT);
        chk(d, 32'h0000_0380);
        @(posedge i_mclk);
        stuck <= 0;
        pass(0, 0, 2'b01);
        repeat (10) @(negedge i_mclk);
        chk({o_coil[0], o_latch_err}, 0);
        $display("t_err done");
    endtask : t_err
    // Second contact starts closed from the coil model: its open command drives its open coil
    task automatic t_pair();
        pass(0, 2'b01, 2'b00);
        chk(o_coil, 4'h2);
        repeat (10) @(negedge i_mclk);
        chk({o_coil, i_latch_pos}, 6'h03);
        repeat (OVL) @(negedge i_mclk);
        pass(0, 2'b00, 2'b10);
        chk(o_coil, 4'h4);
        repeat (10) @(negedge i_mclk);
        chk({o_coil, i_latch_pos}, 6'h01);
        rd(ROC_ADDR_STAT);
        chk(d[17:8], 10'h001);
        $display("t_pair done");
    endtask : t_pair
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim
    initial begin
        i_mclk = 0;
        forever #50 i_mclk = ~i_mclk;
    end
    initial begin
        i_sys_rst = 1;
        i_axi = '0;
        i_pass = 0;
        stuck = 0;
        i_operands = '0;
        i_close_cmd = '0;
        i_open_cmd = '0;
        i_trip_current = '0;
        repeat (2) @(posedge i_mclk);
        i_sys_rst <= 0;
        // A pass before the power-up read has settled must move nothing
        pass(16'hFFFF, 2'b11, 2'b00);
        chk({o_coil, o_plain_out}, 8'h00);
        repeat (3) @(negedge i_mclk);
        chk(o_logic_ready, 1);
        t_regs();
        t_plain();
        t_latch();
        t_err();
        t_pair();
        end_sim();
    end
    // Whole run is about 180 cycles of 100 ns; this bound only catches a hang
    initial begin
        #100_000;
        mismatches++;
        $display("[ERR] %0t watchdog expired", $time);
        end_sim();
    end
endmodule : test_roc_top
`default_nettype wire
